// ### rtl/frmrp_pkg.sv
package frmrp_pkg;

  // Register offsets on the serial programming port
  localparam logic [11:0] FRMRP_OFS_INDEX = 12'h418;
  localparam logic [11:0] FRMRP_OFS_DATA = 12'h41C;
  localparam logic [11:0] FRMRP_OFS_MEMCTL = 12'h420;

  // Reset values
  localparam logic [31:0] FRMRP_RST_INDEX = 32'h00000000;
  localparam logic [31:0] FRMRP_RST_DATA = 32'h00000000;
  localparam logic [31:0] FRMRP_RST_MEMCTL = 32'h1EF80008;

  // Index register fields
  localparam int FRMRP_SEL_LSB = 8;
  localparam int FRMRP_SEL_W = 2;
  localparam int FRMRP_IDX_W = 6;

  // Memory control register fields
  localparam int FRMRP_CTL_W = 5;
  localparam int FRMRP_BIT_LATE = 4;
  localparam int FRMRP_BIT_EDGE = 3;
  localparam int FRMRP_BIT_LOAD = 2;
  localparam int FRMRP_BIT_CLKINV = 1;
  localparam int FRMRP_BIT_TYPE = 0;

  // Table geometry and select codes
  localparam int FRMRP_ROWS = 32;
  localparam int FRMRP_WORD_W = 32;
  localparam int FRMRP_TABLES = 3;
  localparam logic [1:0] FRMRP_SEL_ALL = 2'h0;
  localparam logic [1:0] FRMRP_SEL_RED = 2'h1;
  localparam logic [1:0] FRMRP_SEL_GREEN = 2'h2;
  localparam logic [1:0] FRMRP_SEL_BLUE = 2'h3;

  // External frame buffer read data width
  localparam int FRMRP_MEM_W = 32;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [FRMRP_WORD_W-1:0] wdata;
  } frmrp_req_s;

  typedef struct packed {
    logic ack;
    logic [FRMRP_WORD_W-1:0] rdata;
  } frmrp_rsp_s;

  typedef struct packed {
    logic valid;
    logic [FRMRP_MEM_W-1:0] rise;
    logic [FRMRP_MEM_W-1:0] fall;
  } frmrp_mem_s;

  typedef struct packed {
    logic [FRMRP_SEL_W-1:0] sel;
    logic [FRMRP_IDX_W-1:0] index;
    logic [FRMRP_CTL_W-1:0] memctl;
    frmrp_rsp_s rsp;
    logic load_pulse;
    logic late_valid;
    logic [FRMRP_MEM_W-1:0] late_data;
    logic cap_valid;
    logic [FRMRP_MEM_W-1:0] cap_data;
  } frmrp_state_s;

endpackage : frmrp_pkg

// ### rtl/frmrp_table_ram.sv
`timescale 1ns/10ps
`default_nettype none

// One colour table: rows of two words, word chosen by the index LSB
module frmrp_table_ram
  import frmrp_pkg::*;
#(
  parameter int ROWS = FRMRP_ROWS,
  parameter int IDX_W = FRMRP_IDX_W
) (
  // Clock
  input wire logic i_core_clk,
  // Word access
  input wire logic i_we,
  input wire logic [IDX_W-1:0] i_index,
  input wire logic [FRMRP_WORD_W-1:0] i_wdata,
  output logic [FRMRP_WORD_W-1:0] o_rdata
);

  logic [2*FRMRP_WORD_W-1:0] mem [ROWS];
  logic [IDX_W-2:0] row;

  assign row = i_index[IDX_W-1:1];
  // Even index is the low half of a row, odd index the high half
  assign o_rdata = i_index[0] ? mem[row][2*FRMRP_WORD_W-1:FRMRP_WORD_W]
                              : mem[row][FRMRP_WORD_W-1:0];

  always_ff @(posedge i_core_clk) begin
    if (i_we) begin
      if (i_index[0]) begin
        mem[row][2*FRMRP_WORD_W-1:FRMRP_WORD_W] <= i_wdata;
      end else begin
        mem[row][FRMRP_WORD_W-1:0] <= i_wdata;
      end
    end
  end

endmodule : frmrp_table_ram

`default_nettype wire

// ### rtl/frmrp_port.sv
// Contract
// - Each data register read or write advances the index.
// - Each data access moves one 32-bit word at select and index.
// - Late latch set captures read data one clock later, else at once.
// - Edge select zero takes rising edge data, one takes falling.
// - Edge, late and load settings matter only for dual-scan panels, edge and late only in EDO.
// - Setting the SDRAM load bit loads the SDRAM mode register.
// - Select 00 reads red, writes all; 01, 10, 11 are red, green, blue.
// - 32 rows of 64 bits: even index low word, odd index high word.
// - Frame buffer type zero is EDO, one is SDRAM, dual scan only.
`timescale 1ns/10ps
`default_nettype none

module frmrp_port
  import frmrp_pkg::*;
(
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // Serial programming register port
  input wire frmrp_req_s i_req,
  output frmrp_rsp_s o_rsp,
  // Panel mode and frame buffer read data
  input wire logic i_panel_dual_scan,
  input wire frmrp_mem_s i_mem,
  output logic [FRMRP_MEM_W-1:0] o_mem_data,
  output logic o_mem_data_valid,
  // Frame buffer controls
  output logic o_sdram_mode_load,
  output logic o_sdram_clk_invert,
  output logic o_frame_buffer_type
);

  function automatic logic [FRMRP_TABLES-1:0] frmrp_wr_mask(
    input logic [1:0] sel
  );
    case (sel)
      FRMRP_SEL_RED: frmrp_wr_mask = 3'h1;
      FRMRP_SEL_GREEN: frmrp_wr_mask = 3'h2;
      FRMRP_SEL_BLUE: frmrp_wr_mask = 3'h4;
      default: frmrp_wr_mask = 3'h7;
    endcase
  endfunction : frmrp_wr_mask

  function automatic logic [FRMRP_WORD_W-1:0] frmrp_rd_pick(
    input logic [1:0] sel,
    input logic [FRMRP_WORD_W-1:0] r,
    input logic [FRMRP_WORD_W-1:0] g,
    input logic [FRMRP_WORD_W-1:0] b
  );
    case (sel)
      FRMRP_SEL_GREEN: frmrp_rd_pick = g;
      FRMRP_SEL_BLUE: frmrp_rd_pick = b;
      default: frmrp_rd_pick = r;
    endcase
  endfunction : frmrp_rd_pick

  frmrp_state_s st;
  frmrp_state_s next_st;
  logic [FRMRP_WORD_W-1:0] tbl_rdata [FRMRP_TABLES];
  logic [FRMRP_TABLES-1:0] tbl_we;
  logic data_wr;
  logic data_acc;
  logic ctl_wr;
  logic edo_mode;
  logic [FRMRP_MEM_W-1:0] pick;
  logic [FRMRP_WORD_W-1:0] sel_rdata;

  // Write takes priority if both strobes arrive together
  assign data_wr = i_req.wr && (i_req.addr == FRMRP_OFS_DATA);
  assign data_acc = (i_req.wr || i_req.rd) && (i_req.addr == FRMRP_OFS_DATA);
  assign ctl_wr = i_req.wr && (i_req.addr == FRMRP_OFS_MEMCTL);
  assign tbl_we = data_wr ? frmrp_wr_mask(st.sel) : 3'h0;
  assign sel_rdata = frmrp_rd_pick(st.sel, tbl_rdata[0], tbl_rdata[1],
                                   tbl_rdata[2]);

  // Edge and late controls only apply to EDO on a dual-scan panel
  assign edo_mode = i_panel_dual_scan &&
                    !st.memctl[FRMRP_BIT_TYPE];
  assign pick = (edo_mode && st.memctl[FRMRP_BIT_EDGE]) ?
                i_mem.fall : i_mem.rise;

  for (genvar t = 0; t < FRMRP_TABLES; t++) begin : g_tbl
    frmrp_table_ram #(
      .ROWS(FRMRP_ROWS),
      .IDX_W(FRMRP_IDX_W)
    ) u_ram (
      .i_core_clk(i_core_clk),
      .i_we(tbl_we[t]),
      .i_index(st.index),
      .i_wdata(i_req.wdata),
      .o_rdata(tbl_rdata[t])
    );
  end

  always_comb begin
    next_st = st;
    next_st.rsp.ack = i_req.wr || i_req.rd;
    next_st.load_pulse = 1'b0;
    if (i_req.wr) begin
      case (i_req.addr)
        FRMRP_OFS_INDEX: begin
          next_st.sel = i_req.wdata[FRMRP_SEL_LSB +: FRMRP_SEL_W];
          next_st.index = i_req.wdata[FRMRP_IDX_W-1:0];
        end
        FRMRP_OFS_MEMCTL: begin
          next_st.memctl = i_req.wdata[FRMRP_CTL_W-1:0];
        end
        default: begin
        end
      endcase
    end else if (i_req.rd) begin
      case (i_req.addr)
        FRMRP_OFS_INDEX: next_st.rsp.rdata = {22'h000000, st.sel, 2'h0,
                                             st.index};
        FRMRP_OFS_DATA: next_st.rsp.rdata = sel_rdata;
        FRMRP_OFS_MEMCTL: next_st.rsp.rdata =
          {FRMRP_RST_MEMCTL[31:FRMRP_CTL_W], st.memctl};
        default: next_st.rsp.rdata = 32'h00000000;
      endcase
    end
    // Six-bit add wraps on its own
    if (data_acc) begin
      next_st.index = st.index + 6'h01;
    end
    // Mode register load only means something with a frame buffer attached
    if (ctl_wr && i_req.wdata[FRMRP_BIT_LOAD] && i_panel_dual_scan) begin
      next_st.load_pulse = 1'b1;
    end
    next_st.late_valid = i_mem.valid && i_panel_dual_scan;
    next_st.late_data = pick;
    if (!i_panel_dual_scan) begin
      next_st.cap_valid = 1'b0;
    end else if (edo_mode && st.memctl[FRMRP_BIT_LATE]) begin
      next_st.cap_valid = st.late_valid;
      next_st.cap_data = st.late_data;
    end else begin
      next_st.cap_valid = i_mem.valid;
      next_st.cap_data = pick;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st <= '0;
      st.sel <= FRMRP_RST_INDEX[FRMRP_SEL_LSB +: FRMRP_SEL_W];
      st.index <= FRMRP_RST_INDEX[FRMRP_IDX_W-1:0];
      st.memctl <= FRMRP_RST_MEMCTL[FRMRP_CTL_W-1:0];
      st.rsp.rdata <= FRMRP_RST_DATA;
    end else begin
      st <= next_st;
    end
  end

  assign o_rsp = st.rsp;
  assign o_mem_data = st.cap_data;
  assign o_mem_data_valid = st.cap_valid;
  assign o_sdram_mode_load = st.load_pulse;
  assign o_sdram_clk_invert = st.memctl[FRMRP_BIT_CLKINV];
  assign o_frame_buffer_type = st.memctl[FRMRP_BIT_TYPE];

  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);

  logic late_mode;
  logic plain_mode;
  assign late_mode = edo_mode && st.memctl[FRMRP_BIT_LATE];
  assign plain_mode = i_panel_dual_scan && !late_mode;

  property p_index_step;
    data_acc |=> st.index == $past(st.index) + 6'h01;
  endproperty
  a_index_step: assert property (p_index_step)
    else $error("index did not advance after data access");

  property p_index_wrap;
    (data_acc && st.index == 6'h3F) |=> st.index == 6'h00;
  endproperty
  a_index_wrap: assert property (p_index_wrap)
    else $error("index did not wrap to zero");

  property p_read_word;
    (i_req.rd && !i_req.wr && i_req.addr == FRMRP_OFS_DATA) |=>
      o_rsp.ack && o_rsp.rdata == $past(sel_rdata);
  endproperty
  a_read_word: assert property (p_read_word)
    else $error("data read returned wrong word");

  property p_write_all;
    (data_wr && st.sel == FRMRP_SEL_ALL) |-> tbl_we == 3'h7;
  endproperty
  a_write_all: assert property (p_write_all)
    else $error("select zero did not write all tables");

  property p_late;
    (late_mode && i_mem.valid) ##1 late_mode |=>
      o_mem_data_valid && o_mem_data == $past(pick, 2);
  endproperty
  a_late: assert property (p_late)
    else $error("late latch did not add one clock");

  property p_no_late;
    (plain_mode && i_mem.valid) |=> o_mem_data_valid &&
      o_mem_data == $past(pick);
  endproperty
  a_no_late: assert property (p_no_late)
    else $error("data not latched without delay");

  property p_fall_edge;
    (edo_mode && st.memctl[FRMRP_BIT_EDGE] && !st.memctl[FRMRP_BIT_LATE]
     && i_mem.valid) |=> o_mem_data == $past(i_mem.fall);
  endproperty
  a_fall_edge: assert property (p_fall_edge)
    else $error("falling edge data not selected");

  property p_sdram_ignore;
    (i_panel_dual_scan && st.memctl[FRMRP_BIT_TYPE] && i_mem.valid) |=>
      o_mem_data == $past(i_mem.rise);
  endproperty
  a_sdram_ignore: assert property (p_sdram_ignore)
    else $error("edo controls acted in sdram mode");

  property p_single_scan;
    !i_panel_dual_scan |=> !o_mem_data_valid && !o_sdram_mode_load;
  endproperty
  a_single_scan: assert property (p_single_scan)
    else $error("frame buffer active without dual scan");

  property p_load;
    (ctl_wr && i_req.wdata[FRMRP_BIT_LOAD] && i_panel_dual_scan) |=>
      o_sdram_mode_load;
  endproperty
  a_load: assert property (p_load)
    else $error("sdram mode load not pulsed");

  // Back-to-back load writes may pulse on consecutive cycles
  property p_load_only;
    o_sdram_mode_load |->
      $past(ctl_wr && i_req.wdata[FRMRP_BIT_LOAD] && i_panel_dual_scan);
  endproperty
  a_load_only: assert property (p_load_only)
    else $error("sdram mode load pulsed without a request");

  c_data_write: cover property (data_wr ##1 data_wr);
  c_late_capture: cover property (late_mode && i_mem.valid ##2
                                  o_mem_data_valid);
  c_mode_load: cover property (o_sdram_mode_load);

endmodule : frmrp_port

`default_nettype wire

// ### sim/frmrp_host_model.sv
`timescale 1ns/10ps
`default_nettype none

// Host software on the programming port, one access every two cycles
module frmrp_host_model
  import frmrp_pkg::*;
(
  // Clock
  input wire logic i_core_clk,
  // Register port
  output frmrp_req_s o_req,
  input wire frmrp_rsp_s i_rsp
);
  initial o_req = '0;

  task automatic access(input logic wr, input logic [11:0] addr,
      input logic [31:0] wdata, output logic ack, output logic [31:0] rdata);
    @(posedge i_core_clk);
    o_req <= '{wr: wr, rd: !wr, addr: addr, wdata: wdata};
    @(posedge i_core_clk);
    // Released lines carry the inverse so stale values never look valid
    o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wdata};
    #1;
    ack = i_rsp.ack;
    rdata = i_rsp.rdata;
  endtask : access

  // Index written once as zero, then the whole table streamed
  task automatic fill(input logic [31:0] base);
    logic a;
    logic [31:0] r;
    access(1'b1, FRMRP_OFS_INDEX, 32'h0, a, r);
    for (int i = 0; i < 64; i++) begin
      access(1'b1, FRMRP_OFS_DATA, base + i, a, r);
    end
  endtask : fill
endmodule : frmrp_host_model

`default_nettype wire

// ### sim/frmrp_port_tb.sv
`timescale 1ns/10ps
`default_nettype none

module frmrp_port_tb
  import frmrp_pkg::*;
;
  localparam logic [31:0] P = 32'hA500_0000;
  localparam logic [31:0] R = 32'h0F0F_0001;
  localparam logic [31:0] F = 32'hF0F0_0002;
  logic i_core_clk = 1'b0;
  logic i_srst = 1'b1;
  logic i_panel_dual_scan = 1'b0;
  frmrp_mem_s i_mem = '0;
  frmrp_req_s req;
  frmrp_rsp_s rsp;
  logic [31:0] o_mem_data;
  logic o_mem_data_valid;
  logic o_sdram_mode_load;
  logic o_sdram_clk_invert;
  logic o_frame_buffer_type;
  int n_errors = 0;
  int checked = 0;
  int n_load = 0;

  always #5 i_core_clk = ~i_core_clk;
  always @(negedge i_core_clk) if (o_sdram_mode_load === 1'b1) n_load++;

  frmrp_port dut_u (.i_core_clk(i_core_clk), .i_srst(i_srst), .i_req(req),
    .o_rsp(rsp), .i_panel_dual_scan(i_panel_dual_scan), .i_mem(i_mem),
    .o_mem_data(o_mem_data), .o_mem_data_valid(o_mem_data_valid),
    .o_sdram_mode_load(o_sdram_mode_load),
    .o_sdram_clk_invert(o_sdram_clk_invert),
    .o_frame_buffer_type(o_frame_buffer_type));
  frmrp_host_model host_u (.i_core_clk(i_core_clk), .o_req(req),
    .i_rsp(rsp));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic k;
    logic [31:0] r;
    host_u.access(1'b1, a, d, k, r);
    chk({31'h0, k}, 32'h1);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    logic k;
    logic [31:0] r;
    host_u.access(1'b0, a, 32'h0, k, r);
    chk({31'h0, k}, 32'h1);
    chk(r, e);
  endtask : rd

  task automatic t_reset;
    rd(FRMRP_OFS_INDEX, FRMRP_RST_INDEX);
    rd(FRMRP_OFS_MEMCTL, FRMRP_RST_MEMCTL);
    chk({31'h0, o_frame_buffer_type}, 32'h0);
  endtask : t_reset

  task automatic t_tables;
    host_u.fill(P);
    rd(FRMRP_OFS_INDEX, 32'h0);
    wr(FRMRP_OFS_INDEX, 32'h100);
    for (int i = 0; i < 64; i++) begin
      rd(FRMRP_OFS_DATA, P + i);
    end
    wr(FRMRP_OFS_INDEX, 32'h23E);
    rd(FRMRP_OFS_DATA, P + 32'h3E);
    rd(FRMRP_OFS_DATA, P + 32'h3F);
    rd(FRMRP_OFS_INDEX, 32'h200);
    wr(FRMRP_OFS_INDEX, 32'h205);
    wr(FRMRP_OFS_DATA, 32'h1234_5678);
    rd(FRMRP_OFS_INDEX, 32'h206);
    wr(FRMRP_OFS_INDEX, 32'h205);
    rd(FRMRP_OFS_DATA, 32'h1234_5678);
    wr(FRMRP_OFS_INDEX, 32'h105);
    rd(FRMRP_OFS_DATA, P + 32'h05);
    wr(FRMRP_OFS_INDEX, 32'h107);
    wr(FRMRP_OFS_DATA, 32'h0BAD_0007);
    wr(FRMRP_OFS_INDEX, 32'h007);
    rd(FRMRP_OFS_DATA, 32'h0BAD_0007);
    wr(FRMRP_OFS_INDEX, 32'h307);
    rd(FRMRP_OFS_DATA, P + 32'h07);
    wr(FRMRP_OFS_INDEX, 32'h004);
    wr(FRMRP_OFS_DATA, 32'hCAFE_0004);
    wr(FRMRP_OFS_INDEX, 32'h304);
    rd(FRMRP_OFS_DATA, 32'hCAFE_0004);
    wr(12'h500, 32'hFFFF_FFFF);
    rd(12'h500, 32'h0);
  endtask : t_tables

  task automatic t_load(input logic dual, input int exp);
    int n0;
    @(posedge i_core_clk);
    i_panel_dual_scan <= dual;
    n0 = n_load;
    wr(FRMRP_OFS_MEMCTL, 32'h4);
    repeat (2) @(negedge i_core_clk);
    chk(32'(n_load - n0), 32'(exp));
    rd(FRMRP_OFS_MEMCTL, 32'h1EF8_0004);
  endtask : t_load

  task automatic cap(input logic [31:0] ctl, input logic dual,
      input int lat, input logic fall);
    logic [31:0] got;
    logic [31:0] d;
    wr(FRMRP_OFS_MEMCTL, ctl);
    @(posedge i_core_clk);
    i_panel_dual_scan <= dual;
    i_mem <= '{valid: 1'b1, rise: R, fall: F};
    @(posedge i_core_clk);
    i_mem <= '{valid: 1'b0, rise: ~R, fall: ~F};
    got = 32'h0;
    d = 32'h0;
    for (int k = 1; k <= 4; k++) begin
      @(negedge i_core_clk);
      if (o_mem_data_valid === 1'b1 && got == 0) begin
        got = 32'(k);
        d = o_mem_data;
      end
    end
    chk(got, 32'(lat));
    if (lat != 0) chk(d, fall ? F : R);
  endtask : cap

  task automatic t_memctl;
    t_load(1'b1, 1);
    t_load(1'b0, 0);
    wr(FRMRP_OFS_MEMCTL, 32'h3);
    chk({30'h0, o_sdram_clk_invert, o_frame_buffer_type},
        32'h3);
    cap(32'h00, 1'b1, 1, 1'b0);
    cap(32'h08, 1'b1, 1, 1'b1);
    cap(32'h10, 1'b1, 2, 1'b0);
    cap(32'h18, 1'b1, 2, 1'b1);
    cap(32'h19, 1'b1, 1, 1'b0);
    cap(32'h00, 1'b0, 0, 1'b0);
  endtask : t_memctl

  // Mid-run reset with the registers away from their reset values
  task automatic t_rerst;
    wr(FRMRP_OFS_INDEX, 32'h312);
    wr(FRMRP_OFS_MEMCTL, 32'h13);
    @(posedge i_core_clk);
    i_srst <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    i_srst <= 1'b0;
    rd(FRMRP_OFS_INDEX, FRMRP_RST_INDEX);
    rd(FRMRP_OFS_MEMCTL, FRMRP_RST_MEMCTL);
    chk({30'h0, o_sdram_clk_invert, o_frame_buffer_type},
        32'h0);
    chk({31'h0, o_mem_data_valid}, 32'h0);
  endtask : t_rerst

  task automatic final_report;
    if (n_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  initial begin
    repeat (4) @(posedge i_core_clk);
    i_srst <= 1'b0;
    t_reset();
    t_tables();
    t_memctl();
    t_rerst();
    final_report();
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge i_core_clk);
    n_errors++;
    final_report();
  end
endmodule : frmrp_port_tb

`default_nettype wire
